// File: hw/nvsq_consts.svh
`ifndef NVSQ_CONSTS_SVH
`define NVSQ_CONSTS_SVH

`define NVSQ_SEQ_ADDR0        14'h0E38
`define NVSQ_SEQ_ADDR1        14'h31C7
`define NVSQ_SEQ_ADDR2        14'h03E0
`define NVSQ_SEQ_ADDR3        14'h3C1F
`define NVSQ_SEQ_ADDR4        14'h303F
`define NVSQ_STORE_ADDR       14'h0FC0
`define NVSQ_RECALL_ADDR      14'h0C63
`define NVSQ_MATCH_BITS       14
`define NVSQ_ACC_CYCLES       8
`define NVSQ_STORE_DUR_NS     10000000
`define NVSQ_RECALL_DUR_NS    20000
`define NVSQ_PUP_RECALL_NS    20000000
`define NVSQ_CLK_NS           10
`define NVSQ_STORE_CYC        ((`NVSQ_STORE_DUR_NS + `NVSQ_CLK_NS - 1) / `NVSQ_CLK_NS)
`define NVSQ_RECALL_CYC       ((`NVSQ_RECALL_DUR_NS + `NVSQ_CLK_NS - 1) / `NVSQ_CLK_NS)
`define NVSQ_PUP_RECALL_CYC   ((`NVSQ_PUP_RECALL_NS + `NVSQ_CLK_NS - 1) / `NVSQ_CLK_NS)

`endif

// File: hw/nvsq_pkg.sv
package nvsq_pkg;
  typedef enum logic [6:0] {
    NVSQ_IDLE   = 7'h01,
    NVSQ_PUP    = 7'h02,
    NVSQ_SETUP  = 7'h04,
    NVSQ_STROBE = 7'h08,
    NVSQ_GAP    = 7'h10,
    NVSQ_WAIT   = 7'h20,
    NVSQ_DONE   = 7'h40
  } nvsq_state_t;

  typedef enum logic [1:0] {
    NVSQ_OP_READ   = 2'h0,
    NVSQ_OP_WRITE  = 2'h1,
    NVSQ_OP_STORE  = 2'h2,
    NVSQ_OP_RECALL = 2'h3
  } nvsq_op_t;
endpackage

// File: hw/nvsq_host.sv
// Behaviour
// R01 - store starts only after six chip-select framed reads in exact order
// R02 - steps one to three read 0x0E38, 0x31C7, 0x03E0
// R03 - steps four and five read 0x3C1F then 0x303F
// R04 - sixth read of 0x0FC0 starts a nonvolatile store
// R05 - sixth read of 0x0C63 starts a nonvolatile recall
// R06 - any other access between steps aborts the sequence
// R07 - store erases old nonvolatile data then programs from memory
// R08 - device ignores accesses until the store has finished
// R09 - host holds write strobe high during all six sequence reads
// R10 - sequence steps count with or without output gate low
// R11 - after store duration normal reads and writes resume
// R12 - recall clears array, copies nonvolatile data, then accesses resume
// R13 - recall leaves nonvolatile data intact; unlimited recalls allowed
// R14 - device latches recall at power-up, runs it above switch threshold
// R15 - host keeps write strobe and chip select high during power-up recall
// R16 - below switch threshold stores and writes are ignored
// R17 - only lower fourteen address bits take part in matching
// R18 - each sequence read still returns the addressed byte
// R19 - chip select and write strobe both low make a write
// R20 - after abort the detector expects step one again
`include "nvsq_consts.svh"

module nvsq_host
  import nvsq_pkg::*;
#(
  parameter int unsigned ACC_CYCLES     = `NVSQ_ACC_CYCLES,
  parameter int unsigned STORE_CYC      = `NVSQ_STORE_CYC,
  parameter int unsigned RECALL_CYC     = `NVSQ_RECALL_CYC,
  parameter int unsigned PUP_RECALL_CYC = `NVSQ_PUP_RECALL_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        req_valid_i,
  input  wire logic [1:0]  req_op_i,
  input  wire logic [14:0] req_addr_i,
  input  wire logic [7:0]  req_wdata_i,
  input  wire logic        req_oe_i,
  input  wire logic        supply_ok_i,
  input  wire logic [7:0]  data_lines_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_rdata_o,
  output logic             busy_o,
  output logic [14:0]      address_lines_o,
  output logic [7:0]       data_lines_o,
  output logic             data_lines_oe_o,
  output logic             chip_sel_n_o,
  output logic             write_n_o,
  output logic             out_gate_n_o
);

  localparam int unsigned CW = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // supply status sync: three stages, change counts when stages two and three agree
  logic [2:0] sup_sync_ff;
  logic       sup_ok_ff;
  wire        sup_agree = (sup_sync_ff[1] == sup_sync_ff[2]);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sup_sync_ff <= 3'h0;
      sup_ok_ff   <= 1'b0;
    end else begin
      sup_sync_ff <= {sup_sync_ff[1:0], supply_ok_i};
      if (sup_agree) begin
        sup_ok_ff <= sup_sync_ff[2];
      end
    end
  end

  // data pins pass three stages too; the byte stands the whole strobe, so the
  // only cost is latency: keep ACC_CYCLES at four or more or the capture sees old data
  logic [7:0] dq_s0_ff, dq_s1_ff, dq_s2_ff;
  wire        dq_agree = (dq_s1_ff == dq_s2_ff);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dq_s0_ff <= 8'h00;
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
    end else begin
      dq_s0_ff <= data_lines_i;
      dq_s1_ff <= dq_s0_ff;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state and datapath registers
  nvsq_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [2:0]  step_ff, nxt_step;
  nvsq_op_t    op_ff, nxt_op;
  logic [14:0] addr_ff, nxt_addr;
  logic [7:0]  wdata_ff, nxt_wdata;
  logic        oe_ff, nxt_oe;
  logic        sup_seen_ff;
  logic        rsp_valid_ff, nxt_rsp_valid;
  logic [7:0]  rdata_ff, nxt_rdata;

  // the six sequence addresses, last depends on requested operation
  wire [13:0] seq_addr =
    (step_ff == 3'h0) ? `NVSQ_SEQ_ADDR0 :                        // R02
    (step_ff == 3'h1) ? `NVSQ_SEQ_ADDR1 :                        // R02
    (step_ff == 3'h2) ? `NVSQ_SEQ_ADDR2 :                        // R02
    (step_ff == 3'h3) ? `NVSQ_SEQ_ADDR3 :                        // R03
    (step_ff == 3'h4) ? `NVSQ_SEQ_ADDR4 :                        // R03
    (op_ff == NVSQ_OP_STORE) ? `NVSQ_STORE_ADDR : `NVSQ_RECALL_ADDR; // R04 R05

  wire is_seq    = (op_ff == NVSQ_OP_STORE) || (op_ff == NVSQ_OP_RECALL);
  wire is_write  = (op_ff == NVSQ_OP_WRITE);
  wire last_step = (step_ff == 3'h5);
  // top address bit kept at zero during sequence reads; it plays no part in matching
  wire [14:0] drive_addr = is_seq ? {1'b0, seq_addr} : addr_ff;   // R17
  // store blocked below threshold, device would ignore it anyway
  wire op_blocked = !sup_ok_ff && ((req_op_i == NVSQ_OP_WRITE) ||
                                   (req_op_i == NVSQ_OP_STORE));  // R16
  wire cnt_zero = (cnt_ff == '0);
  wire [CW-1:0] nv_wait = (op_ff == NVSQ_OP_STORE) ? CW'(STORE_CYC)
                                                   : CW'(RECALL_CYC);

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_zero ? cnt_ff : cnt_ff - CW'(1);
    nxt_step      = step_ff;
    nxt_op        = op_ff;
    nxt_addr      = addr_ff;
    nxt_wdata     = wdata_ff;
    nxt_oe        = oe_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rdata     = rdata_ff;
    case (state_ff)
      NVSQ_PUP: begin
        // hold bus idle through the automatic recall after supply comes up
        if (sup_ok_ff && !sup_seen_ff) begin                      // R14 R15
          nxt_cnt = CW'(PUP_RECALL_CYC);
        end else if (sup_ok_ff && cnt_zero) begin
          nxt_state = NVSQ_IDLE;
        end
      end
      NVSQ_IDLE: begin
        if (!sup_ok_ff) begin
          nxt_state = NVSQ_PUP;                                   // R14
        end else if (req_valid_i && !op_blocked) begin
          nxt_op    = nvsq_op_t'(req_op_i);
          nxt_addr  = req_addr_i;
          nxt_wdata = req_wdata_i;
          nxt_oe    = req_oe_i;                                   // R10
          nxt_step  = 3'h0;
          nxt_state = NVSQ_SETUP;
        end else if (req_valid_i) begin
          nxt_rsp_valid = 1'b1;
        end
      end
      NVSQ_SETUP: begin
        nxt_cnt   = CW'(ACC_CYCLES);
        nxt_state = NVSQ_STROBE;
      end
      NVSQ_STROBE: begin
        if (cnt_zero) begin
          nxt_rdata = dq_agree ? dq_s2_ff : rdata_ff;             // R18
          nxt_state = NVSQ_GAP;
        end
      end
      NVSQ_GAP: begin
        // steps go back to back with nothing else between them
        if (is_seq && !last_step) begin                           // R01 R06 R20
          nxt_step  = step_ff + 3'h1;
          nxt_state = NVSQ_SETUP;
        end else if (is_seq) begin
          nxt_cnt   = nv_wait;                                    // R07 R12
          nxt_state = NVSQ_WAIT;
        end else begin
          nxt_state = NVSQ_DONE;
        end
      end
      NVSQ_WAIT: begin
        if (cnt_zero) begin                                       // R08 R11 R12 R13
          nxt_state = NVSQ_DONE;
        end
      end
      NVSQ_DONE: begin
        nxt_rsp_valid = 1'b1;
        nxt_state     = NVSQ_IDLE;
      end
      default: nxt_state = NVSQ_PUP;
    endcase
  end

  wire in_strobe = (state_ff == NVSQ_STROBE);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff     <= NVSQ_PUP;
      cnt_ff       <= '0;
      step_ff      <= 3'h0;
      op_ff        <= NVSQ_OP_READ;
      addr_ff      <= 15'h0000;
      wdata_ff     <= 8'h00;
      oe_ff        <= 1'b0;
      sup_seen_ff  <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rdata_ff     <= 8'h00;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      step_ff      <= nxt_step;
      op_ff        <= nxt_op;
      addr_ff      <= nxt_addr;
      wdata_ff     <= nxt_wdata;
      oe_ff        <= nxt_oe;
      sup_seen_ff  <= sup_ok_ff;
      rsp_valid_ff <= nxt_rsp_valid;
      rdata_ff     <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins registered; address set a cycle before chip select falls
  // write strobe and data outlast chip select by a cycle so the write ends on
  // chip select with data still held, never racing the strobe edge
  wire strobe_live = (nxt_state == NVSQ_STROBE) && in_strobe;
  wire strobe_tail = (nxt_state == NVSQ_STROBE) || in_strobe;
  wire nxt_cs_n    = !strobe_live;
  wire nxt_we_n    = !(strobe_tail && is_write && sup_ok_ff);             // R09 R16 R19
  wire nxt_oe_n    = !(strobe_live && !is_write && oe_ff);
  wire nxt_dq_oe   = strobe_tail && is_write;
  wire nxt_ready = (nxt_state == NVSQ_IDLE) && sup_ok_ff;
  wire nxt_busy  = (nxt_state == NVSQ_WAIT) || (nxt_state == NVSQ_PUP);

  logic [14:0] pin_addr_ff;
  logic        cs_n_ff, we_n_ff, oe_n_ff, dq_oe_ff, ready_ff, busy_ff;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_addr_ff <= 15'h0000;
      cs_n_ff     <= 1'b1;
      we_n_ff     <= 1'b1;
      oe_n_ff     <= 1'b1;
      dq_oe_ff    <= 1'b0;
      ready_ff    <= 1'b0;
      busy_ff     <= 1'b1;
    end else begin
      pin_addr_ff <= (in_strobe || state_ff == NVSQ_SETUP) ? drive_addr : pin_addr_ff;
      cs_n_ff     <= nxt_cs_n;
      we_n_ff     <= nxt_we_n;
      oe_n_ff     <= nxt_oe_n;
      dq_oe_ff    <= nxt_dq_oe;
      ready_ff    <= nxt_ready;
      busy_ff     <= nxt_busy;
    end
  end

  assign address_lines_o = pin_addr_ff;
  assign data_lines_o    = wdata_ff;
  assign data_lines_oe_o = dq_oe_ff;
  assign chip_sel_n_o    = cs_n_ff;
  assign write_n_o       = we_n_ff;
  assign out_gate_n_o    = oe_n_ff;
  assign req_ready_o     = ready_ff;
  assign rsp_valid_o     = rsp_valid_ff;
  assign rsp_rdata_o     = rdata_ff;
  assign busy_o          = busy_ff;

endmodule

// File: bench/nvsq_dev_model.sv
module nvsq_dev_model #(
  parameter int STORE_NS  = 150,
  parameter int RECALL_NS = 80
) (
  input  wire logic [14:0] address_lines_i,
  input  wire logic [7:0]  data_lines_i,
  input  wire logic        sel_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        gate_n_i,
  input  wire logic        pwr_i,
  output logic      [7:0]  data_lines_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] SEQ [5] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
  logic [7:0]  mem [32768];
  logic [7:0]  nv  [32768] = '{default: 8'h00};
  logic [13:0] a;
  logic        busy = 1'b0;
  logic        tog  = 1'b0;
  int          step = 0;
  ////////////////////////////////////////
  assign a = address_lines_i[13:0];
  always #3 tog = ~tog;
  // released bus keeps moving so a stale byte never reads as valid
  assign data_lines_o = (!sel_n_i && wr_n_i && !gate_n_i && !busy) ?
                        mem[address_lines_i] : {8{tog}} ^ 8'h5A;
  task automatic nv_op(input logic st, input int ns);
    busy = 1'b1;
    if (st) begin
      nv = '{default: 8'hFF};
      nv = mem;
    end else begin
      mem = '{default: 8'h00};
      mem = nv;
    end
    #(ns) busy = 1'b0;
  endtask
  always @(posedge pwr_i) nv_op(1'b0, RECALL_NS);
  always @(posedge sel_n_i) begin
    if (busy) step = 0;
    else if (!wr_n_i) begin
      step = 0;
      if (pwr_i) mem[address_lines_i] = data_lines_i;
    end
    else if (step == 5 && a == 14'h0FC0 && pwr_i) nv_op(1'b1, STORE_NS);
    else if (step == 5 && a == 14'h0C63) nv_op(1'b0, RECALL_NS);
    if (!busy && wr_n_i) step = (step < 5 && a == SEQ[step]) ? step + 1 : int'(a == SEQ[0]);
  end
endmodule

// File: bench/nvsq_host_sva.sv
module nvsq_host_sva (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        req_valid_i,
  input wire logic [1:0]  req_op_i,
  input wire logic        supply_ok_i,
  input wire logic        req_ready_o,
  input wire logic        rsp_valid_o,
  input wire logic        busy_o,
  input wire logic [14:0] address_lines_o,
  input wire logic        data_lines_oe_o,
  input wire logic        chip_sel_n_o,
  input wire logic        write_n_o,
  input wire logic        out_gate_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic seq_ff;
  ////////////////////////////////////////
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) seq_ff <= 1'b0;
    else if (req_valid_i && req_ready_o && req_op_i[1]) seq_ff <= 1'b1;
    else if (rsp_valid_o) seq_ff <= 1'b0;
  end
  chk_seq_no_write: assert property (seq_ff |-> write_n_o)
    else $error("write in sequence");
  chk_seq_bit_low: assert property (seq_ff && !chip_sel_n_o |-> !address_lines_o[14])
    else $error("top bit set");
  chk_write_drive: assert property (!chip_sel_n_o && !write_n_o |-> data_lines_oe_o)
    else $error("write undriven");
  chk_gate_read: assert property (!out_gate_n_o |-> !chip_sel_n_o && write_n_o)
    else $error("gate outside read");
  chk_addr_hold: assert property ((!chip_sel_n_o)[*2] |-> $stable(address_lines_o))
    else $error("address moved");
  chk_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("long response");
  chk_busy_quiet: assert property (busy_o |-> chip_sel_n_o && !req_ready_o)
    else $error("access while busy");
  chk_supply_drop: assert property ($fell(supply_ok_i) && req_ready_o |-> ##[1:8] busy_o)
    else $error("no wait on drop");
  chk_write_hold: assert property ($rose(chip_sel_n_o) && !$past(write_n_o) |-> !write_n_o && data_lines_oe_o)
    else $error("write data released early");
  chk_addr_setup: assert property ($fell(chip_sel_n_o) |-> $stable(address_lines_o))
    else $error("address late at select");
endmodule

bind nvsq_host nvsq_host_sva chk_i (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
  .supply_ok_i(supply_ok_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
  .busy_o(busy_o), .address_lines_o(address_lines_o), .data_lines_oe_o(data_lines_oe_o),
  .chip_sel_n_o(chip_sel_n_o), .write_n_o(write_n_o), .out_gate_n_o(out_gate_n_o));

// File: bench/tb_nvsq_host.sv
module tb_nvsq_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        rstn_i, req_valid_i, req_oe_i, supply_ok_i;
  logic        req_ready_o, rsp_valid_o, busy_o, data_lines_oe_o;
  logic        chip_sel_n_o, write_n_o, out_gate_n_o;
  logic [1:0]  req_op_i;
  logic [14:0] req_addr_i, address_lines_o, a0;
  logic [7:0]  req_wdata_i, rsp_rdata_o, data_lines_o, dev_q, bus;
  logic [7:0]  sm [32768] = '{default: 8'h00};
  logic [7:0]  nv [32768] = '{default: 8'h00};
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  ////////////////////////////////////////
  assign bus = data_lines_oe_o ? data_lines_o : dev_q;
  always #5 mclk_i = ~mclk_i;
  nvsq_host #(.STORE_CYC(20), .RECALL_CYC(10), .PUP_RECALL_CYC(10)) dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_oe_i(req_oe_i),
    .supply_ok_i(supply_ok_i), .data_lines_i(bus), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o),
    .address_lines_o(address_lines_o), .data_lines_o(data_lines_o),
    .data_lines_oe_o(data_lines_oe_o), .chip_sel_n_o(chip_sel_n_o),
    .write_n_o(write_n_o), .out_gate_n_o(out_gate_n_o));
  nvsq_dev_model dev (.address_lines_i(address_lines_o), .data_lines_i(bus),
    .sel_n_i(chip_sel_n_o), .wr_n_i(write_n_o), .gate_n_i(out_gate_n_o),
    .pwr_i(supply_ok_i), .data_lines_o(dev_q));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bench model follows each finished request; reads are compared against it
  task automatic req(input logic [1:0] op, input logic [14:0] a, input logic oe);
    while (req_ready_o !== 1'b1) @(negedge mclk_i);
    {req_valid_i, req_op_i, req_addr_i, req_wdata_i, req_oe_i} = {1'b1, op, a, 8'($urandom), oe};
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1) @(negedge mclk_i);
    if (op == 2'h1) sm[a] = req_wdata_i;
    if (op == 2'h2) nv = sm;
    if (op == 2'h3) sm = nv;
    if (op == 2'h0) chk(rsp_rdata_o, sm[a]);
  endtask
  // bounds any hang on a handshake wait
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    {rstn_i, req_valid_i, req_op_i, req_addr_i, req_wdata_i, req_oe_i, supply_ok_i} = '0;
    a0 = 15'($urandom(32'hBABF7191));
    repeat (5) @(negedge mclk_i);
    rstn_i = 1'b1;
    supply_ok_i = 1'b1;
    repeat (10) begin
      a0 = 15'($urandom);
      req(2'h1, a0, 1'b1);
      req(2'h0, a0, 1'b1);
    end
    req(2'h1, 15'h0FC0, 1'b1);
    req(2'h2, 15'h0000, 1'b1);
    chk(rsp_rdata_o, sm[15'h0FC0]);
    for (int k = 0; k < 4; k++) begin
      req(2'h1, a0, 1'b1);
      req(k ? 2'h3 : 2'h2, a0, k[1]);
      req(2'h0, a0, 1'b1);
    end
    req(2'h1, a0, 1'b1);
    supply_ok_i = 1'b0;
    repeat (8) @(negedge mclk_i);
    chk({7'h00, busy_o}, 8'h01);
    chk({7'h00, req_ready_o}, 8'h00);
    supply_ok_i = 1'b1;
    sm = nv;
    req(2'h0, a0, 1'b1);
    print_verdict();
  end
endmodule
